// file: rtl/cxd_line_decoder.v
// Word address latch and X/Y read/write switch and driver decoding
// Functional notes
// - In 8K mode X has sixteen switch pairs and eight driver pairs, Y has eight of each, every pair a read and a write element.
// - In 8K mode one driver and one switch per axis address 128 X lines and 64 Y lines, any of 8192 words.
// - In 4K mode each axis uses eight switch and eight driver pairs, 64 lines per axis, any of 4096 words.
// - A read enables per axis exactly one positive read driver and one negative read switch.
// - A write enables per axis exactly one positive write switch and one negative write driver.
// - Only address bits 13 down to 1 take part in word decoding.
// - Bit 1 comes from the bank selector, bits 12 to 2 straight from the bus receivers.
// - In 4K mode bit 13 ignores the bus and is strapped inactive.
// - Bits 6, 12 and 13 are ANDed with the select strobe into six block selects, one hot per axis.
// - A line decoder drives an output only while its block enable is low.
// - The active-low read select drives the weight-4 input, low choosing read elements.
// - The two lowest decoder inputs pick one of the four pairs in the group.
// - Each decoder weights inputs 1, 2, 4, 8 and drives one of eight outputs low, none when weight 8 is high.
// - Driver decoders are enabled only while the driver timing gate is high.
// - All word address flip-flops load together on the rising edge of the load clock; the code drops a load while either strobe is high.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cxd_consts.vh"

module cxd_line_decoder
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Address inputs
  input  wire [17:0] bus_addr,
  input  wire        word_bit1_from_selector,
  input  wire        addr_load_clk,
  // Size straps
  input  wire        small_size_strap,
  input  wire        large_size_strap,
  // Timing from control logic
  input  wire        select_timing_strobe,
  input  wire        driver_timing_gate,
  input  wire        read_sel_n,
  // Decoder outputs, active low, 8 per decoder
  output wire [31:0] x_sw_dec_n,
  output wire [15:0] x_drv_dec_n,
  output wire [15:0] y_sw_dec_n,
  output wire [15:0] y_drv_dec_n,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ****************************************************************
  // Word address latch
  // ****************************************************************
  reg  [13:1]                wa_r;
  reg                        load_clk_d_r;
  reg  [`CXD_LOADCNT_W-1:0]  load_cnt_r;
  reg  [31:0]                ctrl_r;
  reg  [8*`CXD_NUM_DEC-1:0]  dec_r;
  wire                       size_8k;
  wire                       bit13_in;
  wire                       load_edge;
  wire                       busy;
  wire                       dec_en;
  wire [13:1]                wa_nxt;
  wire [`CXD_LOADCNT_W-1:0]  load_cnt_nxt;

  // Both straps alike falls back to 4K, the safe smaller stack
  assign size_8k   = large_size_strap & ~small_size_strap;
  assign bit13_in  = size_8k ? bus_addr[13] : 1'b0;
  assign load_edge = addr_load_clk & ~load_clk_d_r;
  // Address is frozen while any strobe runs so read and restore agree
  assign busy      = select_timing_strobe | driver_timing_gate;
  assign dec_en    = ctrl_r[`CXD_CTRL_EN_BIT];
  // Bit 0 and bits above 13 never reach the latch
  assign wa_nxt    = {bit13_in, bus_addr[12:2],
                      word_bit1_from_selector};
  assign load_cnt_nxt = load_cnt_r + 16'h0001;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wa_r         <= 13'h0000;
      load_clk_d_r <= 1'b0;
      load_cnt_r   <= 16'h0000;
    end
    else
    begin
      load_clk_d_r <= addr_load_clk;
      if (load_edge && !busy)
      begin
        wa_r       <= wa_nxt;
        load_cnt_r <= load_cnt_nxt;
      end
    end
  end

  // ****************************************************************
  // Block selects and decoder inputs
  // ****************************************************************
  // Decoder order: 0-3 X switch, 4-5 X driver, 6-7 Y switch, 8-9 Y driver
  wire [5:0]                 blk_sel;
  wire [`CXD_NUM_DEC-1:0]    blk_en_n;
  wire [2*`CXD_NUM_DEC-1:0]  lsb_sel;
  wire [8*`CXD_NUM_DEC-1:0]  dec_n;

  // Six selects, one hot per axis, only while the select strobe is high
  assign blk_sel[0] = select_timing_strobe & ~wa_r[6];
  assign blk_sel[1] = select_timing_strobe &  wa_r[6];
  assign blk_sel[2] = select_timing_strobe & ~wa_r[12] & ~wa_r[13];
  assign blk_sel[3] = select_timing_strobe &  wa_r[12] & ~wa_r[13];
  assign blk_sel[4] = select_timing_strobe & ~wa_r[12] &  wa_r[13];
  assign blk_sel[5] = select_timing_strobe &  wa_r[12] &  wa_r[13];

  // Per-decoder enable terms, high when that decoder may conduct
  wire                       xs_en0;
  wire                       xs_en1;
  wire                       xs_en2;
  wire                       xs_en3;
  wire                       xd_en0;
  wire                       xd_en1;
  wire                       ys_en0;
  wire                       ys_en1;
  wire                       yd_en0;
  wire                       yd_en1;

  // X switches need bit 13, so only two of four groups open in 4K mode
  assign xs_en0 = blk_sel[2];
  assign xs_en1 = blk_sel[3];
  assign xs_en2 = blk_sel[4];
  assign xs_en3 = blk_sel[5];
  // Driver groups follow bits 9 and 3, only inside the driver gate
  assign xd_en0 = driver_timing_gate & ~wa_r[9];
  assign xd_en1 = driver_timing_gate &  wa_r[9];
  assign ys_en0 = blk_sel[0];
  assign ys_en1 = blk_sel[1];
  assign yd_en0 = driver_timing_gate & ~wa_r[3];
  assign yd_en1 = driver_timing_gate &  wa_r[3];

  // Control enable off holds every decoder dark
  assign blk_en_n = ~({yd_en1, yd_en0, ys_en1, ys_en0, xd_en1, xd_en0,
                       xs_en3, xs_en2, xs_en1, xs_en0}
                      & {`CXD_NUM_DEC{dec_en}});

  // Pair select inputs per decoder group
  wire [1:0]                 xs_pair;
  wire [1:0]                 xd_pair;
  wire [1:0]                 ys_pair;
  wire [1:0]                 yd_pair;
  assign xs_pair = wa_r[8:7];
  assign xd_pair = wa_r[11:10];
  assign ys_pair = wa_r[2:1];
  assign yd_pair = wa_r[5:4];

  assign lsb_sel = {yd_pair, yd_pair, ys_pair, ys_pair,
                    xd_pair, xd_pair,
                    xs_pair, xs_pair, xs_pair, xs_pair};

  // ****************************************************************
  // Line decoders
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `CXD_NUM_DEC; g = g + 1)
    begin : g_dec
      // Outputs 0-3 read elements, 4-7 write elements
      assign dec_n[8*g+7:8*g] = blk_en_n[g] ? `CXD_DEC_ALL_HIGH :
        ~(`CXD_DEC_ONE << {read_sel_n, lsb_sel[2*g+1:2*g]});
    end
  endgenerate

  // Registered so the base drive sees glitch-free levels,
  // at the cost of one clock of delay after each strobe edge
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dec_r <= {(8*`CXD_NUM_DEC){1'b1}};
    end
    else
    begin
      dec_r <= dec_n;
    end
  end

  // Read: positive read driver plus negative read switch per axis;
  // write: positive write switch plus negative write driver
  assign x_sw_dec_n  = dec_r[31:0];
  assign x_drv_dec_n = dec_r[47:32];
  assign y_sw_dec_n  = dec_r[63:48];
  assign y_drv_dec_n = dec_r[79:64];

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  reg         aw_have_r;
  reg         w_have_r;
  reg  [3:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  integer     i;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CXD_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `CXD_CTRL_RESET;
    end
    else
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        s_axi_awready <= 1'b0;
        aw_have_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end
      else if (!aw_have_r && !s_axi_bvalid)
      begin
        s_axi_awready <= 1'b1;
      end

      if (s_axi_wready && s_axi_wvalid)
      begin
        s_axi_wready <= 1'b0;
        w_have_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      else if (!w_have_r && !s_axi_bvalid)
      begin
        s_axi_wready <= 1'b1;
      end

      if (aw_have_r && w_have_r && !s_axi_bvalid)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_r)
          `CXD_OFS_CTRL:
          begin
            s_axi_bresp <= `CXD_RESP_OKAY;
            for (i = 0; i < 4; i = i + 1)
              if (wstrb_r[i])
                ctrl_r[8*i +: 8] <= wdata_r[8*i +: 8];
          end
          // Status and load count ignore writes
          `CXD_OFS_STATUS,
          `CXD_OFS_LOADCNT:
            s_axi_bresp <= `CXD_RESP_OKAY;
          default:
            s_axi_bresp <= `CXD_RESP_DECERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register read words
  // ****************************************************************
  wire [31:0]                ctrl_word;
  wire [31:0]                status_word;
  wire [31:0]                loadcnt_word;

  // Only bit 0 of control has meaning; the rest read back as zero
  // Busy reports the freeze window in which loads are dropped
  assign ctrl_word    = {31'h0000_0000, ctrl_r[`CXD_CTRL_EN_BIT]};
  assign status_word  = {14'h0000, busy, size_8k, 3'h0, wa_r};
  assign loadcnt_word = {16'h0000, load_cnt_r};

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CXD_RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `CXD_RESP_OKAY;
      case (s_axi_araddr)
        `CXD_OFS_CTRL:
          s_axi_rdata <= ctrl_word;
        `CXD_OFS_STATUS:
          s_axi_rdata <= status_word;
        `CXD_OFS_LOADCNT:
          s_axi_rdata <= loadcnt_word;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CXD_RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
    else if (!s_axi_rvalid)
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // cxd_line_decoder

// file: rtl/cxd_consts.vh
// Constants for the core stack X/Y line select decoder
`ifndef CXD_CONSTS_VH
`define CXD_CONSTS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define CXD_ADDR_W        4
`define CXD_OFS_CTRL      4'h0
`define CXD_OFS_STATUS    4'h4
`define CXD_OFS_LOADCNT   4'h8

// ****************************************************************
// Fields
// ****************************************************************
`define CXD_CTRL_EN_BIT   0
`define CXD_CTRL_RESET    32'h0000_0001
`define CXD_ST_ADDR_LSB   0
`define CXD_ST_SIZE8K_BIT 16
`define CXD_ST_BUSY_BIT   17
`define CXD_LOADCNT_W     16

// ****************************************************************
// Bus responses
// ****************************************************************
`define CXD_RESP_OKAY     2'b00
`define CXD_RESP_DECERR   2'b11

// ****************************************************************
// Decoder geometry
// ****************************************************************
`define CXD_NUM_DEC       10
`define CXD_DEC_OUTS      8
`define CXD_DEC_ALL_HIGH  8'hff
`define CXD_DEC_ONE       8'h01

`endif

// file: testbench/cxd_line_decoder_assertions.sv
// Concurrent checks on the line select decoder ports
`timescale 1ns/1ps
module cxd_chk (
  // Clock, reset and timing
  input wire        aclk, aresetn, addr_load_clk,
  input wire        select_timing_strobe, driver_timing_gate,
  input wire        read_sel_n,
  // Decoder outputs
  input wire [31:0] x_sw_dec_n,
  input wire [15:0] x_drv_dec_n, y_sw_dec_n, y_drv_dec_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [79:0] all_n = {x_sw_dec_n, x_drv_dec_n, y_sw_dec_n, y_drv_dec_n};
  wire        both  = select_timing_strobe && driver_timing_gate;
  sequence s_busy_ld;
    both && $rose(addr_load_clk);
  endsequence
  sequence s_steady;
    (both && $stable(read_sel_n))[*3];
  endsequence
  property p_sw_off;
    !select_timing_strobe |=> &x_sw_dec_n && &y_sw_dec_n;
  endproperty
  property p_drv_off;
    !driver_timing_gate |=> &x_drv_dec_n && &y_drv_dec_n;
  endproperty
  property p_x_one;
    $onehot0(~x_sw_dec_n) && $onehot0(~x_drv_dec_n);
  endproperty
  property p_y_one;
    $onehot0(~y_sw_dec_n) && $onehot0(~y_drv_dec_n);
  endproperty
  property p_rd;
    !read_sel_n |=> &(all_n | {10{8'h0f}});
  endproperty
  property p_wr;
    read_sel_n |=> &(all_n | {10{8'hf0}});
  endproperty
  // Loads under strobe must not move the selected lines
  property p_hold;
    s_busy_ld ##0 s_steady |-> $stable(all_n);
  endproperty
  property p_pair;
    both [*2] |-> $countones(~x_sw_dec_n) == $countones(~x_drv_dec_n)
      && $countones(~y_sw_dec_n) == $countones(~y_drv_dec_n);
  endproperty
  a_sw_off:  assert property (p_sw_off)  else $error("switch on");
  a_drv_off: assert property (p_drv_off) else $error("driver on");
  a_x_one:   assert property (p_x_one)   else $error("x multi");
  a_y_one:   assert property (p_y_one)   else $error("y multi");
  a_rd:      assert property (p_rd)      else $error("rd half");
  a_wr:      assert property (p_wr)      else $error("wr half");
  a_hold:    assert property (p_hold)    else $error("moved");
  a_pair:    assert property (p_pair)    else $error("unpaired");
endmodule // cxd_chk
bind cxd_line_decoder cxd_chk u_cxd_chk (.aclk, .aresetn,
  .addr_load_clk, .select_timing_strobe, .driver_timing_gate,
  .read_sel_n, .x_sw_dec_n, .x_drv_dec_n, .y_sw_dec_n, .y_drv_dec_n);

// file: testbench/cxd_stack_model.sv
// Core stack switch and driver model: reports live line paths
`timescale 1ns/1ps
module cxd_stack_model (
  // Decoder outputs in
  input  wire [31:0] x_sw_dec_n,
  input  wire [15:0] x_drv_dec_n, y_sw_dec_n, y_drv_dec_n,
  // Axis current path, x then y
  output wire [1:0]  line_on
);
  // Current flows only through a switch and driver of one direction
  function path(input [31:0] s, input [15:0] d);
    path = (|(~s & 32'h0f0f0f0f) && |(~d & 16'h0f0f))
        || (|(~s & 32'hf0f0f0f0) && |(~d & 16'hf0f0));
  endfunction
  assign line_on = {path(x_sw_dec_n, x_drv_dec_n),
                    path({16'hffff, y_sw_dec_n}, y_drv_dec_n)};
endmodule // cxd_stack_model

// file: testbench/tb.sv
// Self-checking bench for the line select decoder
`timescale 1ns/1ps
`include "cxd_consts.vh"
module tb;
  reg         aclk = 0, aresetn = 0, ld = 0, a1 = 0, sm = 1, lg = 0;
  reg         stb = 0, drg = 0, rsn = 1, awv = 0, wv = 0, bw = 0;
  reg         arv = 0, rr = 0, big, en = 1, g;
  reg  [17:0] ba = 0, t;
  reg  [3:0]  awa = 0, ara = 0;
  reg  [31:0] wd = 0, rd;
  reg  [1:0]  rs, m;
  reg  [15:0] r0 = 16'hdbc7, r1;
  reg  [12:0] la;
  wire [31:0] xs, rdt;
  wire [15:0] xd, ys, yd;
  wire [1:0]  br, rrs, lon;
  wire        awr, wrd, bv, arr, rv;
  integer     n_mismatch = 0, cmp_count = 0, i, n = 0;
  cxd_line_decoder u_cxd_line_decoder (.aclk(aclk), .aresetn(aresetn),
    .bus_addr(ba), .word_bit1_from_selector(a1), .addr_load_clk(ld),
    .small_size_strap(sm), .large_size_strap(lg),
    .select_timing_strobe(stb), .driver_timing_gate(drg),
    .read_sel_n(rsn), .x_sw_dec_n(xs), .x_drv_dec_n(xd),
    .y_sw_dec_n(ys), .y_drv_dec_n(yd), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bw),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  cxd_stack_model u_cxd_stack_model (.x_sw_dec_n(xs), .x_drv_dec_n(xd),
    .y_sw_dec_n(ys), .y_drv_dec_n(yd), .line_on(lon));
  initial forever #50 aclk = ~aclk;
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function [81:0] exp_dec(input [13:1] a, input r, s, d);
    reg [31:0] x;
    reg [15:0] xv, y, yv;
    begin
      x = 32'hffffffff; xv = 16'hffff; y = 16'hffff; yv = 16'hffff;
      if (s) x[{a[13], a[12], r, a[8], a[7]}] = 1'b0;
      if (d) xv[{a[9], r, a[11], a[10]}] = 1'b0;
      if (s) y[{a[6], r, a[2], a[1]}] = 1'b0;
      if (d) yv[{a[3], r, a[5], a[4]}] = 1'b0;
      exp_dec = {{2{s & d}}, x, xv, y, yv};
    end
  endfunction
  task cmp(input [81:0] s, input [81:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task axw(input [3:0] a, input [31:0] d);
    reg pa, pw;
    begin
      pa = 1; pw = 1;
      awa <= a; wd <= d; awv <= 1; wv <= 1; bw <= 1;
      while (pa || pw)
      begin
        @(posedge aclk);
        if (pa && awr) begin pa = 0; awv <= 0; end
        if (pw && wrd) begin pw = 0; wv <= 0; end
      end
      while (!bv) @(posedge aclk);
      rs = br; bw <= 0;
    end
  endtask
  task axr(input [3:0] a);
    begin
      ara <= a; arv <= 1; rr <= 1;
      do @(posedge aclk); while (!arr);
      arv <= 0;
      while (!rv) @(posedge aclk);
      rd = rdt; rs = rrs; rr <= 0;
    end
  endtask
  task chk(input r, s, d);
    begin
      repeat (3) @(posedge aclk);
      cmp({lon, xs, xd, ys, yd}, exp_dec(la, r, s & en, d & en));
    end
  endtask
  task end_of_test;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #2000000 n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`CXD_OFS_CTRL); cmp(rd, `CXD_CTRL_RESET);
    axr(4'hc); cmp({rs, rd}, {`CXD_RESP_DECERR, 32'h0});
    axw(4'hc, 32'h1); cmp(rs, `CXD_RESP_DECERR);
    axw(`CXD_OFS_STATUS, 32'h1); cmp(rs, `CXD_RESP_OKAY);
    for (i = 0; i < 40; i = i + 1)
    begin
      r1 = nx(r0); r0 = nx(r1);
      t = (i == 0) ? 18'h3ffff : (i == 1) ? 18'h0 : {r0, r1[1:0]};
      m = (i < 2) ? 2'b10 : r1[3:2];
      big = (m == 2'b10);
      la = {big & t[13], t[12:2], t[1] ^ r1[4]};
      g = (i % 4 != 3);
      ba <= t; a1 <= la[0]; {lg, sm} <= m;
      ld <= 1'b1; @(posedge aclk); ld <= 1'b0; n = n + 1;
      repeat (3) @(posedge aclk);
      rsn <= 1'b0; stb <= 1'b1; drg <= g;
      chk(0, 1, g);
      rsn <= 1'b1; ba <= ~t; repeat (2) @(posedge aclk);
      ld <= 1'b1; @(posedge aclk); ld <= 1'b0;
      chk(1, 1, g);
      stb <= 1'b0; drg <= 1'b0;
      chk(1, 0, 0);
      axr(`CXD_OFS_STATUS); cmp({rd[17:16], rd[12:0]}, {1'b0, big, la});
      axr(`CXD_OFS_LOADCNT); cmp(rd, n);
    end
    axw(`CXD_OFS_CTRL, 32'h0); en = 0;
    stb <= 1'b1; drg <= 1'b1; rsn <= 1'b0;
    chk(0, 1, 1);
    axw(`CXD_OFS_CTRL, 32'h1); en = 1;
    chk(0, 1, 1);
    stb <= 1'b0; drg <= 1'b0;
    end_of_test;
  end
endmodule // tb
